// ---- testbench.sv ----
/*
  Self-checking bench for usw_core with a remote serial device.
  Assumes usw_chk is bound into the core.
*/
`timescale 1ns/1ps

module testbench
  import usw_pkg::*;
;
  logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, send = 1'b0;
  logic [7:0]  adr = 8'h00, send_byte = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat_w = 32'h0, dat_r;
  logic        ack, txd, txd_oe, shd, shd_oe, p_line, p_oe, got;
  logic [8:0]  got_frame;
  logic [15:0] bit_clks = 16'd16;  // Clocks per bit now set
  logic [31:0] q_rd[$];            // Expected read data
  logic [31:0] q_ser[$];           // Expected captured frames
  int          fail_count = 0, n_tests = 0;
  // Test table: control one, control two, divisor, clocks per bit
  logic [7:0]  t_c1[3] = '{8'h80, 8'hb0, 8'ha8};
  logic [7:0]  t_c2[3] = '{8'he0, 8'he0, 8'hc8};
  logic [7:0]  t_bd[3] = '{8'h00, 8'h02, 8'h01};
  logic [15:0] t_bc[3] = '{16'd16, 16'd48, 16'd128};
  // Pull-up on both lines when nobody drives
  wire logic   sh_line = shd_oe ? shd : (p_oe ? p_line : 1'b1);
  wire logic   tx_line = txd_oe ? txd : (shd_oe ? shd : 1'b1);

  always #2 clk = ~clk;

  usw_core u_dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .serial_out_pin_o(txd), .serial_out_pin_oe_o(txd_oe), .shared_serial_in_pin_i(sh_line),
    .shared_serial_in_pin_o(shd), .shared_serial_in_pin_oe_o(shd_oe));
  usw_remote u_far (.clk_i(clk), .bit_clks_i(bit_clks), .line_i(tx_line), .send_i(send),
    .send_byte_i(send_byte), .line_o(p_line), .line_oe_o(p_oe), .got_o(got),
    .got_frame_o(got_frame));

  //////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop

  // Classic cycle; for a read, d is the expected byte
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    if (!w) q_rd.push_back({24'h0, d});
    @(posedge clk);
    {cyc, stb, we, adr, sel} <= {1'b1, 1'b1, w, a, 4'h1};
    dat_w <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (!ack && n < 50);
    if (!ack) fail_count++;
    {cyc, stb} <= 2'h0;
  endtask : bus

  // Send one byte, expect it at the far end with parity folded in
  task automatic tx_frame(input logic [7:0] c1, input logic [7:0] d);
    q_ser.push_back({23'h0, 1'b1, c1[C1_PEN] ? {^d[6:0] ^ c1[C1_PTYPE], d[6:0]} : d});
    bus(1'b1, OFF_DATA, d);
    repeat (13 * bit_clks) @(posedge clk);
  endtask : tx_frame

  //////////////////////////////////////////////////////////////////////////
  // Monitor: oldest note against each result
  always @(posedge clk) begin
    if (ack && !we) check("read data", q_rd.pop_front(), dat_r);
    if (got) check("serial frame", q_ser.pop_front(), {23'h0, got_frame});
  end

  // Watchdog well past the expected run
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end

  initial begin
    logic [7:0] d;
    void'($urandom(32'ha13d));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, OFF_CTRL1, 8'h00);
    bus(1'b0, OFF_STATUS, STATUS_RST);
    bus(1'b0, 8'h1c, 8'h00);
    bus(1'b1, OFF_CTRL3, 8'hff);
    bus(1'b0, OFF_CTRL3, 8'h01);
    bus(1'b1, OFF_CTRL3, 8'h00);
    bus(1'b1, OFF_CTRL2, 8'hc0);
    bus(1'b0, OFF_CTRL2, 8'h00);
    bus(1'b1, OFF_MODE, 8'h01);
    // Formats and rates from the table
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, OFF_CTRL1, t_c1[i]);
      bus(1'b1, OFF_BAUD, t_bd[i]);
      bus(1'b1, OFF_CTRL2, t_c2[i]);
      bit_clks <= t_bc[i];
      tx_frame(t_c1[i], 8'($urandom));
      if (i == 0) begin
        d = 8'($urandom);
        send_byte <= d;
        send <= 1'b1;
        @(posedge clk);
        send <= 1'b0;
        repeat (12 * bit_clks) @(posedge clk);
        bus(1'b0, OFF_DATA, d);
      end
    end
    // Global off keeps configuration, resets enables and flags
    bus(1'b1, OFF_CTRL1, 8'h00);
    bus(1'b0, OFF_STATUS, ST_DISMASK);
    bus(1'b0, OFF_CTRL2, 8'h08);
    bus(1'b0, OFF_BAUD, 8'h01);
    bus(1'b1, OFF_CTRL1, 8'h80);
    bus(1'b1, OFF_CTRL2, 8'he8);
    bit_clks <= 16'd32;
    tx_frame(8'h80, 8'($urandom));
    // Single wire: both enables first, then transmit only
    bus(1'b1, OFF_CTRL3, 8'h01);
    bus(1'b0, OFF_CTRL3, 8'h01);
    bus(1'b1, OFF_CTRL2, 8'ha8);
    tx_frame(8'h80, 8'($urandom));
    report_and_stop();
  end
endmodule : testbench

// ---- usw_chk.sv ----
/*
  Port checker for usw_core, bound into every instance.
  Assumes a Wishbone master that holds adr/we/dat until ack.
*/
`timescale 1ns/1ps

module usw_chk
  import usw_pkg::*;
#(
  parameter int ADDR_W = 8  // Same as the core
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  input  wire logic [31:0]       wb_dat_o,
  input  wire logic              wb_ack_o,
  input  wire logic              serial_out_pin_o,
  input  wire logic              serial_out_pin_oe_o,
  input  wire logic              shared_serial_in_pin_i,
  input  wire logic              shared_serial_in_pin_o,
  input  wire logic              shared_serial_in_pin_oe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  //////////////////////////////////////////////////////////////////////////
  // Shadow of control bits, updated on the same edge as the core
  logic ge_ff, tx_ff, rx_ff, sw_ff, md_ff;
  // Write taken on the same edge as the core, so the shadow never lags the pins
  wire logic wr = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
  wire logic rd = wb_ack_o && !wb_we_i;                // Read answered

  // Enables only stick while global enable is on
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {ge_ff, tx_ff, rx_ff, sw_ff, md_ff} <= 5'h00;
    end else if (wr && wb_adr_i == ADDR_W'(OFF_CTRL1)) begin
      ge_ff <= wb_dat_i[C1_GE];
      tx_ff <= tx_ff && wb_dat_i[C1_GE];
      rx_ff <= rx_ff && wb_dat_i[C1_GE];
    end else if (wr && wb_adr_i == ADDR_W'(OFF_CTRL2)) begin
      tx_ff <= ge_ff && wb_dat_i[C2_TXEN];
      rx_ff <= ge_ff && wb_dat_i[C2_RXEN];
    end else if (wr && wb_adr_i == ADDR_W'(OFF_CTRL3)) begin
      sw_ff <= wb_dat_i[0];
    end else if (wr && wb_adr_i == ADDR_W'(OFF_MODE)) begin
      md_ff <= wb_dat_i[0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  property p_ack_lat;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("ack late");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_dat_idle;
    !wb_ack_o |-> wb_dat_o == 32'h0;
  endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("data outside ack");
  property p_ctrl3_rd;
    rd && wb_adr_i == ADDR_W'(OFF_CTRL3) |-> wb_dat_o[31:1] == 31'h0;
  endproperty
  a_ctrl3_rd: assert property (p_ctrl3_rd) else $error("upper bits set");
  property p_unmapped;
    rd && wb_adr_i > ADDR_W'(OFF_MODE) |-> wb_dat_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not zero");
  property p_off_status;
    rd && wb_adr_i == ADDR_W'(OFF_STATUS) && !ge_ff |-> wb_dat_o[7:0] == ST_DISMASK;
  endproperty
  a_off_status: assert property (p_off_status) else $error("flags when off");
  property p_released;
    !ge_ff [*3] |-> !serial_out_pin_oe_o && !shared_serial_in_pin_oe_o;
  endproperty
  a_released: assert property (p_released) else $error("pin held when off");
  property p_mode_gate;
    serial_out_pin_oe_o |-> md_ff && (tx_ff || $past(tx_ff));
  endproperty
  a_mode_gate: assert property (p_mode_gate) else $error("pin without enables");
  property p_swm_off;
    !sw_ff [*3] |-> !shared_serial_in_pin_oe_o;
  endproperty
  a_swm_off: assert property (p_swm_off) else $error("shared pin driven");
  property p_both_rx;
    (sw_ff && tx_ff && rx_ff) [*3] |-> !shared_serial_in_pin_oe_o;
  endproperty
  a_both_rx: assert property (p_both_rx) else $error("shared pin driven");
  property p_idle_high;
    $rose(serial_out_pin_oe_o) |-> serial_out_pin_o;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("line not idle high");
endmodule : usw_chk

bind usw_core usw_chk #(.ADDR_W(ADDR_W)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .serial_out_pin_o(serial_out_pin_o),
  .serial_out_pin_oe_o(serial_out_pin_oe_o), .shared_serial_in_pin_i(shared_serial_in_pin_i),
  .shared_serial_in_pin_o(shared_serial_in_pin_o),
  .shared_serial_in_pin_oe_o(shared_serial_in_pin_oe_o));

// ---- usw_core.sv ----
/*
  Asynchronous serial transceiver core with single-wire option, shared
  data buffer and 8-bit baud generator, behind a classic Wishbone slave.
  Assumes synchronous pin inputs, one clock and a pin mux outside that
  resolves output enables to wire levels.
*/
// Our own choices: the Wishbone interface to the registers and the placing of the registers.
// Summary of operation
// - Single-wire bit picks shared pin role
// - Both enables in single-wire: receive only
// - Single-wire register: bit zero only
// - One data register for both directions
// - Free-running 8-bit baud timer
// - Rate is clock over 64 or 16 times N+1
// - Divisor spans 0 to 255
// - NRZ frame: start, 8/9 data, stops
// - Even, odd or no parity
// - Reset format: 8 bits, no parity, one stop
// - LSB first, shared format and rate
// - Pins active only when fully enabled
// - Idle transmit line rests high
// - Global disable releases both pins
// - Global disable empties data buffer
// - Global disable clears and sets flags
// - Global disable clears both enables and break, keeps other control bits
// - Disable suspends, re-enable resumes configuration
// - Format bits select length, parity, stops
// - MSB marks address when detection on
// - Two stops transmit only; receiver checks one
// - Parity takes last data position
// - Transmitter disable aborts and floats pin
// - Receiver disable aborts; single-wire transmitter then drives shared pin
`timescale 1ns/1ps

module usw_core
  import usw_pkg::*;
#(
  parameter int ADDR_W = 8  // Wishbone byte address width
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  output logic                   serial_out_pin_o,
  output logic                   serial_out_pin_oe_o,
  input  wire logic              shared_serial_in_pin_i,
  output logic                   shared_serial_in_pin_o,
  output logic                   shared_serial_in_pin_oe_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Parameter check

  // Offsets need five bits; decode zero-extends to eight
  if (ADDR_W < 5 || ADDR_W > 8) begin : g_bad_addr_w
    $error("usw_core: ADDR_W must be 5 to 8");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State and combinational temporaries

  usw_state_t  q;         // Registered state
  usw_state_t  n;         // Next state
  logic [7:0]  adr8;      // Decoded byte address
  logic        req;       // New bus request this cycle
  logic        wr;        // Write with low lane enabled
  logic        rd;        // Read request
  logic [7:0]  rdv;       // Read value before registering
  logic        act_tx;    // Transmitter running
  logic        act_rx;    // Receiver running
  logic        pre_done;  // Prescaler period complete
  logic        par;       // Generated parity
  logic [8:0]  d9;        // Outgoing data word with parity
  logic [15:0] frame;     // Outgoing frame, bit 0 first
  logic        maj;       // Majority of three samples
  logic        nz;        // Samples disagreed
  logic [8:0]  dd;        // Received word aligned to bit 0
  logic        addr_bit;  // Received address marker
  logic        ntx;       // Transmitter active after this cycle
  logic        line;      // Transmit line level

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    n        = q;
    adr8     = 8'(wb_adr_i);
    req      = wb_cyc_i & wb_stb_i & ~q.ack;
    wr       = req & wb_we_i & wb_sel_i[0];
    rd       = req & ~wb_we_i;
    rdv      = 8'h00;
    par      = 1'b0;
    d9       = 9'h000;
    frame    = 16'hffff;
    maj      = 1'b1;
    nz       = 1'b0;
    dd       = 9'h000;
    addr_bit = 1'b0;
    pre_done = 1'b0;
    act_tx   = q.ctrl1[C1_GE] & q.mode & q.ctrl2[C2_TXEN];
    act_rx   = q.ctrl1[C1_GE] & q.mode & q.ctrl2[C2_RXEN];

    // Bus answer: one cycle after request, then dropped
    n.ack = req;

    // Read mux; unmapped offsets read zero
    unique case (adr8)
      OFF_CTRL1:  rdv = {q.ctrl1[7:2], q.rx8, q.ctrl1[C1_TX8]};
      OFF_CTRL2:  rdv = q.ctrl2;
      OFF_CTRL3:  rdv = {7'h00, q.swm};
      OFF_DATA:   rdv = q.rx_data;
      OFF_BAUD:   rdv = q.baud;
      OFF_STATUS: rdv = q.status;
      OFF_MODE:   rdv = {7'h00, q.mode};
      default:    rdv = 8'h00;
    endcase
    n.rdat = rd ? rdv : 8'h00;

    // Register writes; status is read only
    if (wr) begin
      unique case (adr8)
        OFF_CTRL1:  n.ctrl1 = (wb_dat_i[7:0] & C1_WMASK) | (q.ctrl1 & ~C1_WMASK);
        OFF_CTRL2:  n.ctrl2 = wb_dat_i[7:0];
        OFF_CTRL3:  n.swm = wb_dat_i[0];
        OFF_BAUD:   n.baud = wb_dat_i[7:0];
        OFF_MODE:   n.mode = wb_dat_i[0];
        OFF_DATA: begin
          // Writes supply transmit byte; inhibited while full
          if (!q.hold_full) begin
            n.tx_hold           = {q.ctrl1[C1_TX8], wb_dat_i[7:0]};
            n.hold_full         = 1'b1;
            n.status[ST_TEMPT]  = 1'b0;
            n.status[ST_TIDLE]  = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // Data read consumes byte and its error flags
    if (rd && adr8 == OFF_DATA) begin
      n.status[ST_RXAV]  = 1'b0;
      n.status[ST_OERR]  = 1'b0;
      n.status[ST_FERR]  = 1'b0;
      n.status[ST_PERR]  = 1'b0;
      n.status[ST_NOISE] = 1'b0;
    end

    //////////////////////////////////////////////////////////////////////////
    // Baud generator: 16 ticks per bit

    // Fixed divide by four in low speed
    n.pre    = q.pre + 2'h1;
    pre_done = q.ctrl2[C2_SPEED] | (q.pre == PRESCALE_LAST);
    n.tick   = 1'b0;
    if (pre_done) begin
      if (q.bcnt == 8'h00) begin
        n.bcnt = q.baud;
        n.tick = 1'b1;
      end else begin
        n.bcnt = q.bcnt - 8'h01;
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // Transmitter

    d9 = {q.ctrl1[C1_WLS] & q.tx_hold[8], q.tx_hold[7:0]};
    par = ^(d9 & (q.ctrl1[C1_WLS] ? 9'h0ff : 9'h07f)) ^ q.ctrl1[C1_PTYPE];
    if (q.ctrl1[C1_PEN]) begin
      if (q.ctrl1[C1_WLS]) begin
        d9[8] = par;
      end else begin
        d9[7] = par;
      end
    end
    frame[0]   = 1'b0;
    frame[8:1] = d9[7:0];
    frame[9]   = q.ctrl1[C1_WLS] ? d9[8] : 1'b1;

    if (!act_tx) begin
      n.tx_busy = 1'b0;
      n.tx_sub  = 4'h0;
      if (!q.ctrl2[C2_TXEN]) begin
        n.hold_full = 1'b0;
      end
    end else if (q.tx_busy) begin
      if (q.tick) begin
        n.tx_sub = q.tx_sub + 4'h1;
        if (q.tx_sub == OVS_LAST) begin
          n.tx_shift = {1'b1, q.tx_shift[15:1]};
          n.tx_cnt   = q.tx_cnt - 5'h01;
          if (q.tx_cnt == 5'h01) begin
            n.tx_busy          = 1'b0;
            n.status[ST_TIDLE] = 1'b1;
          end
        end
      end
    end else if (q.ctrl1[C1_BRK]) begin
      // Break: start plus thirteen zeros, then stops
      n.tx_shift = {2'b11, 14'h0000};
      n.tx_cnt   = BREAK_BITS + (q.ctrl1[C1_STOPS] ? 5'h02 : 5'h01);
      n.tx_sub   = 4'h0;
      n.tx_busy  = 1'b1;
    end else if (q.hold_full) begin
      n.tx_shift         = frame;
      n.tx_cnt           = (q.ctrl1[C1_WLS] ? 5'h0a : 5'h09)
                         + (q.ctrl1[C1_STOPS] ? 5'h02 : 5'h01);
      n.tx_sub           = 4'h0;
      n.tx_busy          = 1'b1;
      n.hold_full        = 1'b0;
      n.status[ST_TEMPT] = 1'b1;
    end

    //////////////////////////////////////////////////////////////////////////
    // Receiver

    // Three-sample vote around bit centre
    maj = (q.s0 & q.s1) | (q.s0 & shared_serial_in_pin_i)
        | (q.s1 & shared_serial_in_pin_i);
    nz  = (q.s0 != q.s1) | (q.s1 != shared_serial_in_pin_i);
    // Align 8-bit words to bit 0
    dd  = q.ctrl1[C1_WLS] ? q.rx_shift : {1'b0, q.rx_shift[8:1]};
    addr_bit = q.ctrl1[C1_WLS] ? dd[8] : dd[7];

    if (!act_rx) begin
      n.rx_st  = RX_IDLE;
      n.rx_sub = 4'h0;
    end else begin
      unique case (q.rx_st)
        RX_IDLE: begin
          if (!shared_serial_in_pin_i) begin
            n.rx_st  = RX_START;
            n.rx_sub = 4'h0;
            n.rx_nz  = 1'b0;
          end
        end
        default: begin
          if (q.tick) begin
            n.rx_sub = q.rx_sub + 4'h1;
            if (q.rx_sub == SAMPLE_A) begin
              n.s0 = shared_serial_in_pin_i;
            end
            if (q.rx_sub == SAMPLE_B) begin
              n.s1 = shared_serial_in_pin_i;
            end
            if (q.rx_sub == SAMPLE_C) begin
              n.rx_bit = maj;
              n.rx_nz  = q.rx_nz | nz;
            end
            // Single stop checked at its centre
            if (q.rx_st == RX_STOP && q.rx_sub == SAMPLE_C) begin
              n.rx_st = RX_IDLE;
              if (!(q.ctrl2[C2_ADDEN] && !addr_bit)) begin
                if (q.status[ST_RXAV] && !(rd && adr8 == OFF_DATA)) begin
                  n.status[ST_OERR] = 1'b1;
                end else begin
                  n.rx_data          = dd[7:0];
                  n.rx8              = dd[8];
                  n.status[ST_RXAV]  = 1'b1;
                  n.status[ST_FERR]  = n.status[ST_FERR] | ~maj;
                  n.status[ST_PERR]  = n.status[ST_PERR]
                                     | (q.ctrl1[C1_PEN] & (^dd ^ q.ctrl1[C1_PTYPE]));
                  n.status[ST_NOISE] = n.status[ST_NOISE] | q.rx_nz | nz;
                end
              end
            end else if (q.rx_sub == OVS_LAST) begin
              if (q.rx_st == RX_START) begin
                // False start returns to idle
                n.rx_st  = q.rx_bit ? RX_IDLE : RX_DATA;
                n.rx_cnt = 4'h0;
              end else if (q.rx_st == RX_DATA) begin
                n.rx_shift = {q.rx_bit, q.rx_shift[8:1]};
                n.rx_cnt   = q.rx_cnt + 4'h1;
                if (q.rx_cnt == (q.ctrl1[C1_WLS] ? 4'h8 : 4'h7)) begin
                  n.rx_st = RX_STOP;
                end
              end
            end
          end
        end
      endcase
    end
    n.status[ST_RIDLE] = (n.rx_st == RX_IDLE);

    //////////////////////////////////////////////////////////////////////////
    // Global disable

    if (!q.ctrl1[C1_GE]) begin
      n.ctrl2[C2_TXEN] = 1'b0;
      n.ctrl2[C2_RXEN] = 1'b0;
      n.ctrl1[C1_BRK]  = 1'b0;
      n.status         = ST_DISMASK;
      n.hold_full      = 1'b0;
    end

    //////////////////////////////////////////////////////////////////////////
    // Pin drive

    ntx  = n.ctrl1[C1_GE] & n.mode & n.ctrl2[C2_TXEN];
    line = n.tx_busy ? n.tx_shift[0] : 1'b1;
    n.txo = line;
    n.sho = line;
    n.txoe = ntx & ~n.swm;
    // Both enables: shared pin not driven
    n.shoe = ntx & n.swm & ~n.ctrl2[C2_RXEN];
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q        <= '0;
      q.ctrl1  <= CTRL_RST;
      q.ctrl2  <= CTRL_RST;
      q.baud   <= BAUD_RST;
      q.status <= STATUS_RST;
      q.rx_st  <= RX_IDLE;
      q.s0     <= 1'b1;
      q.s1     <= 1'b1;
      q.rx_bit <= 1'b1;
      q.txo    <= 1'b1;
      q.sho    <= 1'b1;
    end else begin
      q <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from state

  assign wb_dat_o                  = {24'h000000, q.rdat};
  assign wb_ack_o                  = q.ack;
  assign serial_out_pin_o          = q.txo;
  assign serial_out_pin_oe_o       = q.txoe;
  assign shared_serial_in_pin_o    = q.sho;
  assign shared_serial_in_pin_oe_o = q.shoe;

endmodule : usw_core

// ---- usw_pkg.sv ----
/*
  Shared constants and state types for the single-wire serial transceiver.
  Assumes a 32-bit classic Wishbone register bus with byte addresses.
*/
package usw_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL1  = 8'h00;  // control_reg_one
  localparam logic [7:0] OFF_CTRL2  = 8'h04;  // control_reg_two
  localparam logic [7:0] OFF_CTRL3  = 8'h08;  // single_wire_control
  localparam logic [7:0] OFF_DATA   = 8'h0c;  // serial_data_buffer
  localparam logic [7:0] OFF_BAUD   = 8'h10;  // baud_divisor
  localparam logic [7:0] OFF_STATUS = 8'h14;  // status flags
  localparam logic [7:0] OFF_MODE   = 8'h18;  // serial_module_control

  //////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int C1_GE    = 7;  // global_enable
  localparam int C1_WLS   = 6;  // word_length_select
  localparam int C1_PEN   = 5;  // parity_enable
  localparam int C1_PTYPE = 4;  // parity_type, 1 = odd
  localparam int C1_STOPS = 3;  // stop_count_select
  localparam int C1_BRK   = 2;  // break_request
  localparam int C1_RX8   = 1;  // received ninth bit, read only
  localparam int C1_TX8   = 0;  // ninth bit to transmit
  localparam int C2_TXEN  = 7;  // transmitter_enable
  localparam int C2_RXEN  = 6;  // receiver_enable
  localparam int C2_SPEED = 5;  // speed_select
  localparam int C2_ADDEN = 4;  // address detect enable
  localparam int ST_PERR  = 7;  // parity_error_flag
  localparam int ST_NOISE = 6;  // noise_flag
  localparam int ST_FERR  = 5;  // framing_error_flag
  localparam int ST_OERR  = 4;  // overrun_flag
  localparam int ST_RIDLE = 3;  // receiver_idle_flag
  localparam int ST_RXAV  = 2;  // receive_available_flag
  localparam int ST_TIDLE = 1;  // transmitter_idle_flag
  localparam int ST_TEMPT = 0;  // transmit_empty_flag

  //////////////////////////////////////////////////////////////////////////
  // Reset values and masks
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] BAUD_RST   = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h0b;  // Both idles and empty set
  localparam logic [7:0] C1_WMASK   = 8'hfd;  // Received ninth bit not writable
  localparam logic [7:0] ST_DISMASK = 8'h0b;  // Flags forced high on disable

  //////////////////////////////////////////////////////////////////////////
  // Timing counts
  localparam logic [1:0] PRESCALE_LAST = 2'h3;  // Divide by 4 in low speed
  localparam logic [3:0] OVS_LAST      = 4'hf;  // 16 samples per bit
  localparam logic [3:0] SAMPLE_A      = 4'h7;  // Majority vote samples
  localparam logic [3:0] SAMPLE_B      = 4'h8;
  localparam logic [3:0] SAMPLE_C      = 4'h9;
  localparam logic [4:0] BREAK_BITS    = 5'h0e;  // Start plus 13 zeros

  // Receiver sequencing
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} usw_rx_st_t;

  // Entire state of the core
  typedef struct packed {
    logic [7:0]  ctrl1;
    logic [7:0]  ctrl2;
    logic        swm;
    logic        mode;
    logic [7:0]  baud;
    logic [7:0]  status;
    logic [1:0]  pre;
    logic [7:0]  bcnt;
    logic        tick;
    logic [8:0]  tx_hold;
    logic        hold_full;
    logic [15:0] tx_shift;
    logic [4:0]  tx_cnt;
    logic [3:0]  tx_sub;
    logic        tx_busy;
    usw_rx_st_t  rx_st;
    logic [3:0]  rx_sub;
    logic [3:0]  rx_cnt;
    logic [8:0]  rx_shift;
    logic        s0;
    logic        s1;
    logic        rx_bit;
    logic        rx_nz;
    logic [7:0]  rx_data;
    logic        rx8;
    logic        ack;
    logic [7:0]  rdat;
    logic        txo;
    logic        txoe;
    logic        sho;
    logic        shoe;
  } usw_state_t;

endpackage : usw_pkg

// ---- usw_remote.sv ----
/*
  Remote serial device: sends 8N1 frames on request, captures frames.
  Assumes the bench resolves the released line to its pull-up level.
*/
`timescale 1ns/1ps

module usw_remote (
  input  wire logic        clk_i,
  input  wire logic [15:0] bit_clks_i,
  input  wire logic        line_i,
  input  wire logic        send_i,
  input  wire logic [7:0]  send_byte_i,
  output logic             line_o,
  output logic             line_oe_o,
  output logic             got_o,
  output logic [8:0]       got_frame_o
);
  logic [9:0] fr;  // Outgoing frame
  logic [8:0] rx;  // Captured data plus stop

  initial begin
    {line_o, line_oe_o, got_o, got_frame_o} = 12'h800;
  end

  //////////////////////////////////////////////////////////////////////////
  // start, data LSB first, stop
  always @(posedge clk_i) begin
    if (send_i) begin
      fr = {1'b1, send_byte_i, 1'b0};
      for (int i = 0; i < 10; i++) begin
        line_oe_o <= 1'b1;
        line_o    <= fr[i];
        repeat (bit_clks_i) @(posedge clk_i);
      end
      line_oe_o <= 1'b0;  // Release: bench pull-up takes over
    end
  end

  // mid-bit capture, stop kept in bit 8
  always begin
    @(negedge line_i);
    repeat (bit_clks_i / 2) @(posedge clk_i);
    for (int i = 0; i < 9; i++) begin
      repeat (bit_clks_i) @(posedge clk_i);
      rx[i] = line_i;
    end
    got_frame_o <= rx;
    got_o       <= 1'b1;
    @(posedge clk_i);
    got_o       <= 1'b0;
  end
endmodule : usw_remote
